/* File: rtl/mcfv_defs.svh */
// Constants of the machine-check frame and vector dispatch unit.
// Assumes inclusion by bare name from rtl/ sources only.
`ifndef MCFV_DEFS_SVH
`define MCFV_DEFS_SVH

// Machine-check codes
`define MCFV_CODE_RD_OPER      8'h80
`define MCFV_CODE_RD_SYS       8'h81
`define MCFV_CODE_WR_OPER      8'h82
`define MCFV_CODE_WR_SYS       8'h83

// Vector table byte offsets
`define MCFV_VEC_MCHK          32'h0000_0004
`define MCFV_VEC_KSNV          32'h0000_0008
`define MCFV_VEC_PWRFAIL       32'h0000_000C
`define MCFV_VEC_ACV           32'h0000_0020
`define MCFV_VEC_TNV           32'h0000_0024
`define MCFV_VEC_ARITH         32'h0000_0034

// Frame constants
`define MCFV_MCHK_BYTE_COUNT   32'h0000_0010
`define MCFV_ADDR_BIAS         32'h0000_0004
`define MCFV_WORD_BYTES        32'h0000_0004
`define MCFV_IS1_FIXED         4'hE
`define MCFV_IS2_FIXED_HI      2'h3
`define MCFV_IS2_FIXED_CC      3'h7
`define MCFV_PWRFAIL_IPL       5'h1E
`define MCFV_PSW_IPL_LSB       16
`define MCFV_PSW_IPL_MSB       20

// Register byte offsets
`define MCFV_OFF_KSP           12'h000
`define MCFV_OFF_ISP           12'h004
`define MCFV_OFF_CACHE_CTRL    12'h008
`define MCFV_OFF_MEMORY_SYSTEM_ERROR_REG          12'h00C
`define MCFV_OFF_STATUS        12'h010
`define MCFV_OFF_LAST_FRAME    12'h014
`define MCFV_OFF_VTB           12'h044

// Status register fields
`define MCFV_ST_BUSY_BIT       0
`define MCFV_ST_CODE_LSB       8
`define MCFV_ST_VEC_LSB        16

// Reset values
`define MCFV_RST_WORD          32'h0000_0000

`endif

/* File: rtl/mcfv_pkg.sv */
// Types shared by the machine-check frame and vector dispatch unit.
// Assumes a SystemVerilog compiler; holds no logic.
`default_nettype none

package mcfv_pkg;

    // Source of a failed memory reference
    typedef enum logic [2:0] {
        MCFV_SRC_OPERAND,
        MCFV_SRC_PROC_PAGE,
        MCFV_SRC_INTERLOCK,
        MCFV_SRC_SYS_PAGE,
        MCFV_SRC_CTX_BLOCK,
        MCFV_SRC_VEC_ENTRY
    } mcfv_src_t;

    // Non-machine-check exception kinds
    typedef enum logic [2:0] {
        MCFV_EXC_KSNV,
        MCFV_EXC_PWRFAIL,
        MCFV_EXC_ACV,
        MCFV_EXC_TNV,
        MCFV_EXC_ARITH
    } mcfv_exc_t;

    typedef enum logic [1:0] {
        MCFV_ST_IDLE,
        MCFV_ST_PUSH,
        MCFV_ST_FETCH,
        MCFV_ST_DONE
    } mcfv_state_t;

endpackage : mcfv_pkg

`default_nettype wire

/* File: rtl/mcfv_classify.sv */
// Maps a failed reference to its machine-check code.
// Assumes a combinational use by the frame unit.
`include "mcfv_defs.svh"
`default_nettype none

module mcfv_classify (
    input  wire logic              mc_write,
    input  wire mcfv_pkg::mcfv_src_t mc_src,
    output logic [7:0]             mc_code
);
    import mcfv_pkg::*;

    always_comb begin
        mc_code = `MCFV_CODE_RD_OPER;
        if (!mc_write) begin
            case (mc_src)
                MCFV_SRC_SYS_PAGE, MCFV_SRC_CTX_BLOCK, MCFV_SRC_VEC_ENTRY: begin
                    mc_code = `MCFV_CODE_RD_SYS;
                end
                default: begin
                    mc_code = `MCFV_CODE_RD_OPER;
                end
            endcase
        end else begin
            case (mc_src)
                MCFV_SRC_SYS_PAGE, MCFV_SRC_CTX_BLOCK: begin
                    mc_code = `MCFV_CODE_WR_SYS;
                end
                default: begin
                    mc_code = `MCFV_CODE_WR_OPER;
                end
            endcase
        end
    end

endmodule : mcfv_classify

`default_nettype wire

/* File: rtl/mcfv_frame_pack.sv */
// Packs the address and two internal-state words of the frame.
// Assumes all inputs stand in the cycle of capture.
`include "mcfv_defs.svh"
`default_nettype none

module mcfv_frame_pack (
    input  wire logic [7:0]  mc_code,
    input  wire logic [31:0] mc_vaddr,
    input  wire logic [31:0] mc_paddr,
    input  wire logic [7:0]  opcode,
    input  wire logic [3:0]  sw_irq_level,
    input  wire logic [7:0]  cache_ctrl,
    input  wire logic [7:0]  mem_err,
    input  wire logic [7:0]  shift_count,
    input  wire logic [5:0]  state_flags,
    input  wire logic        restart_blocked_flag,
    input  wire logic [3:0]  cond_codes,
    input  wire logic [31:0] saved_pc,
    input  wire logic [31:0] cur_pc,
    output logic [31:0]      recent_addr,
    output logic [31:0]      state_word1,
    output logic [31:0]      state_word2
);
    logic        phys_sel;
    logic [31:0] pc_diff;

    // Code 81 and 83 report physical addresses
    assign phys_sel    = (mc_code == `MCFV_CODE_RD_SYS) || (mc_code == `MCFV_CODE_WR_SYS);
    assign recent_addr = (phys_sel ? mc_paddr : mc_vaddr) + `MCFV_ADDR_BIAS;
    assign pc_diff     = cur_pc - saved_pc;

    assign state_word1 = {opcode,
                          `MCFV_IS1_FIXED, sw_irq_level,
                          cache_ctrl, mem_err};
    assign state_word2 = {shift_count,
                          `MCFV_IS2_FIXED_HI, state_flags,
                          restart_blocked_flag,
                          `MCFV_IS2_FIXED_CC, cond_codes,
                          pc_diff[7:0]};

endmodule : mcfv_frame_pack

`default_nettype wire

/* File: rtl/mcfv_top.sv */
// Machine-check frame builder and exception vector dispatcher.
// Assumes one memory port answering with a one-cycle ack, and an AHB-Lite master.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`include "mcfv_defs.svh"
`default_nettype none

module mcfv_top #(
    parameter int VTB_ALIGN_BITS = 9
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    // Machine-check request and core state
    input  wire logic              mc_req,
    input  wire logic              mc_write,
    input  wire mcfv_pkg::mcfv_src_t mc_src,
    input  wire logic [31:0]       mc_vaddr,
    input  wire logic [31:0]       mc_paddr,
    input  wire logic [7:0]        opcode,
    input  wire logic [3:0]        sw_irq_level,
    input  wire logic [7:0]        shift_count,
    input  wire logic [5:0]        state_flags,
    input  wire logic              restart_blocked_flag,
    input  wire logic [3:0]        cond_codes,
    input  wire logic [31:0]       saved_pc,
    input  wire logic [31:0]       cur_pc,
    input  wire logic [31:0]       processor_status_word,
    // Other exceptions
    input  wire logic              exc_req,
    input  wire mcfv_pkg::mcfv_exc_t exc_kind,
    input  wire logic [31:0]       exc_param0,
    input  wire logic [31:0]       exc_param1,
    // Memory port
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [31:0]            mem_addr,
    output logic [31:0]            mem_wdata,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata,
    // Dispatch result
    output logic                   disp_valid,
    output logic [31:0]            disp_pc,
    output logic [31:0]            disp_psw,
    output logic                   disp_istack,
    output logic                   busy
);
    import mcfv_pkg::*;

    localparam int FRAME_WORDS = 7;

    // Base alignment must lie between 2 bits (word-aligned vector reads) and 12 bits
    if (VTB_ALIGN_BITS < 2 || VTB_ALIGN_BITS > 12) begin : g_bad_align
        $error("VTB_ALIGN_BITS out of range");
    end

    // Register file
    logic [31:0] ksp_reg;
    logic [31:0] isp_reg;
    logic [31:0] cache_control_reg;
    logic [31:0] memory_system_error_reg;
    logic [31:0] vector_table_base_reg;
    logic [31:0] last_frame_sp_reg;
    logic [7:0]  last_code_reg;
    logic [11:0] last_vec_reg;

    // Dispatch state
    mcfv_state_t state_reg;
    logic [31:0] frame_reg [FRAME_WORDS];
    logic [2:0]  count_reg;
    logic [2:0]  idx_reg;
    logic [31:0] sp_work_reg;
    logic        use_isp_reg;
    logic [31:0] vec_off_reg;
    logic [31:0] new_psw_reg;

    // Bus slave address phase
    logic        bus_wr_pend_reg;
    logic [11:0] bus_addr_reg;
    logic        bus_take;
    logic [11:0] bus_off;

    // Frame contents from the helper modules
    logic [7:0]  mc_code;
    logic [31:0] recent_addr;
    logic [31:0] state_word1;
    logic [31:0] state_word2;
    logic        start_mc;
    logic        start_exc;

    mcfv_classify u_classify (
        .mc_write (mc_write),
        .mc_src   (mc_src),
        .mc_code  (mc_code)
    );

    mcfv_frame_pack u_pack (
        .mc_code              (mc_code),
        .mc_vaddr             (mc_vaddr),
        .mc_paddr             (mc_paddr),
        .opcode               (opcode),
        .sw_irq_level         (sw_irq_level),
        .cache_ctrl           (cache_control_reg[7:0]),
        .mem_err              (memory_system_error_reg[7:0]),
        .shift_count          (shift_count),
        .state_flags          (state_flags),
        .restart_blocked_flag (restart_blocked_flag),
        .cond_codes           (cond_codes),
        .saved_pc             (saved_pc),
        .cur_pc               (cur_pc),
        .recent_addr          (recent_addr),
        .state_word1          (state_word1),
        .state_word2          (state_word2)
    );

    // Machine check outranks other exceptions; requests while busy are dropped
    assign start_mc  = (state_reg == MCFV_ST_IDLE) && mc_req;
    assign start_exc = (state_reg == MCFV_ST_IDLE) && exc_req && !mc_req;

    assign bus_take = hsel && htrans[1] && hready;
    assign bus_off  = haddr[11:0];

    // Capture of the frame, pushed in order from the highest stack address down
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < FRAME_WORDS; i++) begin
                frame_reg[i] <= `MCFV_RST_WORD;
            end
            count_reg   <= 3'h0;
            vec_off_reg <= `MCFV_RST_WORD;
            use_isp_reg <= 1'b0;
            new_psw_reg <= `MCFV_RST_WORD;
        end else if (ce) begin
            if (start_mc) begin
                frame_reg[0] <= processor_status_word;
                frame_reg[1] <= saved_pc;
                frame_reg[2] <= state_word2;
                frame_reg[3] <= state_word1;
                frame_reg[4] <= recent_addr;
                frame_reg[5] <= {24'h00_0000, mc_code};
                frame_reg[6] <= `MCFV_MCHK_BYTE_COUNT;
                count_reg    <= 3'h7;
                vec_off_reg  <= `MCFV_VEC_MCHK;
                use_isp_reg  <= 1'b0;
                new_psw_reg  <= processor_status_word;
            end else if (start_exc) begin
                frame_reg[0] <= processor_status_word;
                frame_reg[1] <= saved_pc;
                frame_reg[2] <= exc_param1;
                frame_reg[3] <= exc_param0;
                frame_reg[4] <= `MCFV_RST_WORD;
                frame_reg[5] <= `MCFV_RST_WORD;
                frame_reg[6] <= `MCFV_RST_WORD;
                use_isp_reg  <= 1'b0;
                new_psw_reg  <= processor_status_word;
                case (exc_kind)
                    MCFV_EXC_KSNV: begin
                        count_reg   <= 3'h2;
                        vec_off_reg <= `MCFV_VEC_KSNV;
                        use_isp_reg <= 1'b1;
                    end
                    MCFV_EXC_PWRFAIL: begin
                        count_reg   <= 3'h2;
                        vec_off_reg <= `MCFV_VEC_PWRFAIL;
                        use_isp_reg <= 1'b1;
                        new_psw_reg[`MCFV_PSW_IPL_MSB:`MCFV_PSW_IPL_LSB] <= `MCFV_PWRFAIL_IPL;
                    end
                    MCFV_EXC_ACV: begin
                        count_reg   <= 3'h4;
                        vec_off_reg <= `MCFV_VEC_ACV;
                    end
                    MCFV_EXC_TNV: begin
                        count_reg   <= 3'h4;
                        vec_off_reg <= `MCFV_VEC_TNV;
                    end
                    MCFV_EXC_ARITH: begin
                        frame_reg[2] <= exc_param0;
                        count_reg    <= 3'h3;
                        vec_off_reg  <= `MCFV_VEC_ARITH;
                    end
                    default: begin
                        count_reg   <= 3'h2;
                        vec_off_reg <= `MCFV_VEC_KSNV;
                        use_isp_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= MCFV_ST_IDLE;
            idx_reg   <= 3'h0;
            busy      <= 1'b0;
        end else if (ce) begin
            case (state_reg)
                MCFV_ST_IDLE: begin
                    idx_reg <= 3'h0;
                    if (start_mc || start_exc) begin
                        state_reg <= MCFV_ST_PUSH;
                        busy      <= 1'b1;
                    end
                end
                MCFV_ST_PUSH: begin
                    if (mem_req && mem_ack) begin
                        if (idx_reg == count_reg - 3'h1) begin
                            state_reg <= MCFV_ST_FETCH;
                        end
                        idx_reg <= idx_reg + 3'h1;
                    end
                end
                MCFV_ST_FETCH: begin
                    // Idle in the dispatch cycle, so busy falls with disp_valid
                    if (mem_req && mem_ack) begin
                        state_reg <= MCFV_ST_IDLE;
                        busy      <= 1'b0;
                    end
                end
                MCFV_ST_DONE: begin
                    state_reg <= MCFV_ST_IDLE;
                end
                default: begin
                    state_reg <= MCFV_ST_IDLE;
                end
            endcase
        end
    end

    // Stack pointer of the frame being pushed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sp_work_reg <= `MCFV_RST_WORD;
        end else if (ce) begin
            if (state_reg == MCFV_ST_IDLE) begin
                sp_work_reg <= (start_exc && (exc_kind == MCFV_EXC_KSNV || exc_kind == MCFV_EXC_PWRFAIL))
                               ? isp_reg : ksp_reg;
            end else if (state_reg == MCFV_ST_PUSH && mem_req && mem_ack) begin
                sp_work_reg <= sp_work_reg - `MCFV_WORD_BYTES;
            end
        end
    end

    // Memory port; request held until acknowledged, then dropped for a cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= `MCFV_RST_WORD;
            mem_wdata <= `MCFV_RST_WORD;
        end else if (ce) begin
            if (mem_req && mem_ack) begin
                mem_req <= 1'b0;
            end else if (!mem_req && state_reg == MCFV_ST_PUSH) begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= sp_work_reg - `MCFV_WORD_BYTES;
                mem_wdata <= frame_reg[idx_reg];
            end else if (!mem_req && state_reg == MCFV_ST_FETCH) begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b0;
                mem_addr  <= vector_table_base_reg + vec_off_reg;
                mem_wdata <= `MCFV_RST_WORD;
            end
        end
    end

    // Dispatch result and stack pointer write-back
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            disp_valid        <= 1'b0;
            disp_pc           <= `MCFV_RST_WORD;
            disp_psw          <= `MCFV_RST_WORD;
            disp_istack       <= 1'b0;
            last_frame_sp_reg <= `MCFV_RST_WORD;
            last_code_reg     <= 8'h00;
            last_vec_reg      <= 12'h000;
        end else if (ce) begin
            disp_valid <= 1'b0;
            if (state_reg == MCFV_ST_FETCH && mem_req && mem_ack) begin
                disp_valid        <= 1'b1;
                disp_pc           <= {mem_rdata[31:2], 2'b00};
                disp_psw          <= new_psw_reg;
                disp_istack       <= use_isp_reg;
                last_frame_sp_reg <= sp_work_reg;
                last_code_reg     <= (vec_off_reg == `MCFV_VEC_MCHK) ? frame_reg[5][7:0] : 8'h00;
                last_vec_reg      <= vec_off_reg[11:0];
            end
        end
    end

    // AHB-Lite: zero wait states, OKAY always; read data registered in the address phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_wr_pend_reg <= 1'b0;
            bus_addr_reg    <= 12'h000;
            hrdata          <= `MCFV_RST_WORD;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
        end else if (ce) begin
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
            bus_wr_pend_reg <= bus_take && hwrite && (hsize == 3'h2);
            bus_addr_reg    <= bus_off;
            if (bus_take && !hwrite) begin
                case (bus_off)
                    `MCFV_OFF_KSP:        hrdata <= ksp_reg;
                    `MCFV_OFF_ISP:        hrdata <= isp_reg;
                    `MCFV_OFF_CACHE_CTRL: hrdata <= cache_control_reg;
                    `MCFV_OFF_MEMORY_SYSTEM_ERROR_REG:       hrdata <= memory_system_error_reg;
                    `MCFV_OFF_STATUS:     hrdata <= {4'h0, last_vec_reg, last_code_reg, 7'h00, busy};
                    `MCFV_OFF_LAST_FRAME: hrdata <= last_frame_sp_reg;
                    `MCFV_OFF_VTB:        hrdata <= vector_table_base_reg;
                    default:              hrdata <= `MCFV_RST_WORD;
                endcase
            end
        end
    end

    // Software-written registers; frame push updates the stack pointer and wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ksp_reg                 <= `MCFV_RST_WORD;
            isp_reg                 <= `MCFV_RST_WORD;
            cache_control_reg       <= `MCFV_RST_WORD;
            memory_system_error_reg <= `MCFV_RST_WORD;
            vector_table_base_reg   <= `MCFV_RST_WORD;
        end else if (ce) begin
            if (bus_wr_pend_reg) begin
                case (bus_addr_reg)
                    `MCFV_OFF_KSP:        ksp_reg <= {hwdata[31:2], 2'b00};
                    `MCFV_OFF_ISP:        isp_reg <= {hwdata[31:2], 2'b00};
                    `MCFV_OFF_CACHE_CTRL: cache_control_reg <= hwdata;
                    `MCFV_OFF_MEMORY_SYSTEM_ERROR_REG:       memory_system_error_reg <= hwdata;
                    // Two-page table: base kept aligned so offsets do not carry when VTB_ALIGN_BITS is 6 or more
                    `MCFV_OFF_VTB:        vector_table_base_reg <= {hwdata[31:VTB_ALIGN_BITS],
                                                                    {VTB_ALIGN_BITS{1'b0}}};
                    default: begin
                    end
                endcase
            end
            if (state_reg == MCFV_ST_FETCH && mem_req && mem_ack) begin
                if (use_isp_reg) begin
                    isp_reg <= sp_work_reg;
                end else begin
                    ksp_reg <= sp_work_reg;
                end
            end
        end
    end

endmodule : mcfv_top

`default_nettype wire

/* File: sim/mcfv_monitor.sv */
// Port checker for mcfv_top.
// Assumes ce held high; bound in from tb_top.
`default_nettype none
module mcfv_monitor (
    input wire logic        ref_clk, rst, ce, mc_req, exc_req, busy, disp_valid, mem_req, mem_we, mem_ack,
    input wire logic [31:0] mem_addr, mem_wdata, disp_pc
);
    logic [31:0] wd_q;
    logic        mc_q;
    // Last pushed word, to see the byte count ahead of the vector read
    always_ff @(posedge ref_clk) begin
        if (ce && !busy && (mc_req || exc_req)) mc_q <= mc_req;
        if (mem_req && mem_we && mem_ack) wd_q <= mem_wdata;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_take; ce && !busy && (mc_req || exc_req) |=> busy; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_vec; mem_req && mem_ack && !mem_we |=> disp_valid; endproperty
    a_vec: assert property (p_vec) else $error("no dispatch after vector");
    property p_align; mem_req && !mem_we |-> mem_addr[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("vector unaligned");
    property p_pc; !disp_valid |-> $stable(disp_pc); endproperty
    a_pc: assert property (p_pc) else $error("handler moved");
    property p_drop; mem_req && mem_ack |=> !mem_req; endproperty
    a_drop: assert property (p_drop) else $error("request kept");
    property p_pulse; disp_valid |-> !busy ##1 !disp_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("dispatch pulse");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata); endproperty
    a_hold: assert property (p_hold) else $error("request changed");
    property p_cnt; mem_req && !mem_we && mc_q |-> wd_q == 32'h00000010; endproperty
    a_cnt: assert property (p_cnt) else $error("bad byte count");
endmodule : mcfv_monitor
`default_nettype wire

/* File: sim/mcfv_mem_model.sv */
// Main memory: stack pushes and vector reads, prompt or slow.
// Assumes a request holds until its ack is seen.
`default_nettype none
module mcfv_mem_model (
    input wire logic        ref_clk, slow, mem_req, mem_we,
    input wire logic [31:0] mem_addr, mem_wdata,
    output logic            mem_ack,
    output logic [31:0]     mem_rdata
);
    timeunit 1ns; timeprecision 1ns;
    logic [31:0] m [logic [31:0]];
    int w = 0;
    initial {mem_ack, mem_rdata} = '0;
    // Data toggles outside the read ack cycle so stale reads show
    always @(posedge ref_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && w < (slow ? 3 : 0)) w <= w + 1;
        else if (mem_req && !mem_ack) begin
            w <= 0;
            mem_ack <= 1'b1;
            if (mem_we) m[mem_addr] = mem_wdata;
            else mem_rdata <= m[mem_addr];
        end
    end
endmodule : mcfv_mem_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Bench: AHB register access, machine checks and other exceptions.
// Assumes mcfv_top, the memory model and the checker.
`default_nettype none
module tb_top;
    import mcfv_pkg::*;
    timeunit 1ns; timeprecision 1ns;
    logic ref_clk, rst, ce, hsel, hwrite, mc_req, mc_write, restart_blocked_flag, exc_req, slow;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] sw_irq_level, cond_codes;
    logic [5:0] state_flags;
    logic [7:0] opcode, shift_count;
    logic [31:0] haddr, hwdata, mc_vaddr, mc_paddr, saved_pc, cur_pc, processor_status_word, exc_param0, exc_param1, r, sp;
    mcfv_src_t mc_src;
    mcfv_exc_t exc_kind;
    wire logic hready, hreadyout, hresp, mem_req, mem_we, mem_ack, disp_valid, disp_istack, busy;
    wire logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata, disp_pc, disp_psw;
    int error_cnt, checks_done, n;
    logic [31:0] off [6] = '{32'h4, 32'h8, 32'hC, 32'h20, 32'h24, 32'h34};
    logic [31:0] nw [5] = '{32'h8, 32'h8, 32'h10, 32'h10, 32'hC};
    logic [7:0] code [8] = '{8'h80, 8'h80, 8'h80, 8'h81, 8'h81, 8'h81, 8'h82, 8'h83};
    logic [2:0] src [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h4};
    assign hready = hreadyout;
    mcfv_top dut (.*);
    mcfv_mem_model mem (.*);
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Bounded wait of one edge; a hang ends the run
    task automatic step;
        @(posedge ref_clk);
        if (++n > 400) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : step
    task automatic bus(input logic w, input logic [31:0] a, d);
        {hsel, htrans, hwrite, haddr} <= {3'h6, w, a};
        n = 0;
        do step(); while (!hreadyout);
        {hsel, htrans, hwdata} <= {3'h0, d};
        do step(); while (!hreadyout);
        r = hrdata;
    endtask : bus
    task automatic go(input logic m);
        {mc_req, exc_req, n} <= {m, !m, 32'h0};
        step();
        {mc_req, exc_req} <= 2'h0;
        do step(); while (!disp_valid);
    endtask : go
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, ce, hsize, mc_src, exc_kind} = {2'h3, 3'h2, MCFV_SRC_OPERAND, MCFV_EXC_KSNV};
        {hsel, hwrite, htrans, haddr, hwdata, mc_req, exc_req, slow, mc_write, restart_blocked_flag} = '0;
        {sw_irq_level, cond_codes, state_flags, opcode, shift_count, mc_vaddr, mc_paddr} = '0;
        {saved_pc, cur_pc, processor_status_word, exc_param0, exc_param1} = '0;
        foreach (off[i]) mem.m[32'h1000 + off[i]] = 32'h5001 + (off[i] << 4);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        bus(1'b0, 32'h44, 32'h0);
        chk(r, 32'h0);
        bus(1'b1, 32'h44, 32'h1000); bus(1'b1, 32'h0, 32'h2000); bus(1'b1, 32'h4, 32'h3000);
        bus(1'b1, 32'h8, 32'hFFA5); bus(1'b1, 32'hC, 32'h7F3C); bus(1'b0, 32'hF0, 32'h0);
        chk(r, 32'h0);
        for (logic [31:0] k = 0; k < 8; k++) begin
            mc_src <= mcfv_src_t'(src[k]);
            {mc_write, slow, opcode, sw_irq_level, shift_count} <= {k > 5, k[0], k[7:0], k[3:0], ~k[7:0]};
            {state_flags, restart_blocked_flag, cond_codes} <= {k[5:0] ^ 6'h2A, k[0], k[3:0] + 4'h1};
            {mc_vaddr, mc_paddr} <= {32'h7000_0000 + (k << 2), 32'h0009_0000 + (k << 2)};
            {saved_pc, cur_pc} <= {32'h4000 + (k << 4), 32'h4003 + (k << 4) + k};
            processor_status_word <= 32'h0400_0000 + k;
            go(1'b1);
            bus(1'b0, 32'h0, 32'h0);
            sp = 32'h2000 - 28 * (k + 1);
            chk(r, sp);
            chk(disp_pc, 32'h5040);
            chk(mem.m[sp], 32'h10);
            chk(mem.m[sp + 4], {24'h0, code[k]});
            chk(mem.m[sp + 8], (code[k][0] ? mc_paddr : mc_vaddr) + 32'h4);
            chk(mem.m[sp + 12], {opcode, 4'hE, sw_irq_level, 16'hA53C});
            r = {shift_count, 2'h3, state_flags, restart_blocked_flag, 3'h7, cond_codes, k[7:0] + 8'h3};
            chk(mem.m[sp + 16], r);
            chk(mem.m[sp + 20], saved_pc);
            chk(mem.m[sp + 24], processor_status_word);
            bus(1'b0, 32'h10, 32'h0);
            chk(r[27:8], {12'h4, code[k]});
        end
        for (logic [31:0] k = 0; k < 5; k++) begin
            exc_kind <= mcfv_exc_t'(k);
            {exc_param0, exc_param1, slow} <= {32'h900 + k, 32'hA00 + k, k[0]};
            bus(1'b0, {29'h0, k < 2, 2'h0}, 32'h0);
            sp = r - nw[k];
            go(1'b0);
            chk(disp_pc, 32'h5000 + (off[k + 1] << 4));
            chk(disp_istack, k < 2);
            if (k == 1) chk(disp_psw[20:16], 5'h1E);
            if (k > 1) chk(mem.m[sp], 32'h900 + k);
            bus(1'b0, {29'h0, k < 2, 2'h0}, 32'h0);
            chk(r, sp);
        end
        tally_and_finish();
    end
endmodule : tb_top
bind mcfv_top mcfv_monitor mon (.*);
`default_nettype wire
